/* File: rtl/rdq_regs.svh */
// Constants of the radio data status query block: codes, bit positions,
// register offsets and reset values.
// Assumes inclusion by bare name from the block's design files.
`ifndef RDQ_REGS_SVH
`define RDQ_REGS_SVH

// ==========================================================================
// Command and argument layout
`define RDQ_CMD_STATUS_QUERY 8'h24
`define RDQ_READ_TOKEN 8'hA0
`define RDQ_CMD_BYTES 4'h2
`define RDQ_RESP_BYTES 4'hC
`define RDQ_ARG_ACK 0
`define RDQ_ARG_FLUSH 1
`define RDQ_ARG_PEEK 2

// ==========================================================================
// Status byte and response bit positions
`define RDQ_ST_CTS 7
`define RDQ_ST_ERR 6
`define RDQ_ST_RSQ 3
`define RDQ_ST_DRDY 2
`define RDQ_ST_STC 0
`define RDQ_R1_NEWB 5
`define RDQ_R1_NEWA 4
`define RDQ_R1_SYNC_ACQ 2
`define RDQ_R1_SYNC_DROP 1
`define RDQ_R1_THRESH 0
`define RDQ_R2_OVERRUN 2
`define RDQ_R2_SYNC 0

// ==========================================================================
// Corrected-error codes
`define RDQ_ERR_NONE 2'h0
`define RDQ_ERR_FIX_1_2 2'h1
`define RDQ_ERR_FIX_3_5 2'h2
`define RDQ_ERR_UNCORR 2'h3

// ==========================================================================
// Register offsets, interrupt bits and reset values
`define RDQ_REG_CTRL 8'h00
`define RDQ_REG_IRQ_STAT 8'h04
`define RDQ_REG_IRQ_MASK 8'h08
`define RDQ_REG_STATE 8'h0C
`define RDQ_IRQ_CMD_DONE 0
`define RDQ_IRQ_DATA_READY 1
`define RDQ_IRQ_OVERRUN 2
`define RDQ_IRQ_SYNC_CHANGE 3
`define RDQ_CTRL_RESET 8'h01
`define RDQ_MASK_RESET 4'h0

`endif

/* File: rtl/rdq_pkg.sv */
// Types shared by the radio data status query block.
// Assumes nothing of its surroundings.
package rdq_pkg;

  // ========================================================================
  // Kind of link frame in progress
  typedef enum logic [1:0] {FR_IDLE, FR_CMD, FR_READ} rdq_frame_t;

endpackage

/* File: rtl/rdq_status_query.sv */
// Radio data status query handler with its receive group queue.
// Assumes a serial link from the host (select, clock, data in) sampled on clk,
// a decoder on clk delivering groups, and a register port on clk.
//
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "rdq_regs.svh"

module rdq_status_query #(
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic link_sel_n,
  input wire logic link_sclk,
  input wire logic link_sdi,
  output logic link_sdo,
  output logic link_sdo_oe,
  input wire logic grp_valid,
  input wire logic [15:0] grp_word_a,
  input wire logic [15:0] grp_word_b,
  input wire logic [15:0] grp_word_c,
  input wire logic [15:0] grp_word_d,
  input wire logic [7:0] grp_error_codes,
  input wire logic sync_present,
  input wire logic tune_to_frequency_cmd,
  input wire logic seek_begin_cmd,
  input wire logic signal_quality_irq,
  input wire logic seek_tune_done_irq,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // ========================================================================
  // Link input synchronisers and edge detection
  logic sclk_s1_ff, sclk_s2_ff, sclk_d_ff;
  logic sel_s1_ff, sel_s2_ff, sel_d_ff;
  logic sdi_s1_ff, sdi_s2_ff;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sclk_s1_ff <= 1'b0;
      sclk_s2_ff <= 1'b0;
      sclk_d_ff <= 1'b0;
      sel_s1_ff <= 1'b1;
      sel_s2_ff <= 1'b1;
      sel_d_ff <= 1'b1;
      sdi_s1_ff <= 1'b0;
      sdi_s2_ff <= 1'b0;
    end
    else
    begin
      sclk_s1_ff <= link_sclk;
      sclk_s2_ff <= sclk_s1_ff;
      sclk_d_ff <= sclk_s2_ff;
      sel_s1_ff <= link_sel_n;
      sel_s2_ff <= sel_s1_ff;
      sel_d_ff <= sel_s2_ff;
      sdi_s1_ff <= link_sdi;
      sdi_s2_ff <= sdi_s1_ff;
    end
  end

  logic sclk_rise, sclk_fall, sel_end;
  assign sclk_rise = sclk_s2_ff & ~sclk_d_ff;
  assign sclk_fall = ~sclk_s2_ff & sclk_d_ff;
  assign sel_end = sel_s2_ff & ~sel_d_ff;

  // ========================================================================
  // Frame receiver: first byte is a command or the read token
  rdq_pkg::rdq_frame_t frame_ff;
  logic [2:0] bit_cnt_ff;
  logic [3:0] byte_cnt_ff;
  logic [6:0] rx_ff;
  logic [7:0] cmd_ff, arg_ff;
  logic [7:0] rx_byte;
  logic byte_done, cmd_taken, token_taken;

  assign rx_byte = {rx_ff, sdi_s2_ff};
  assign byte_done = !sel_s2_ff && sclk_rise && (bit_cnt_ff == 3'h7);
  assign cmd_taken = byte_done && (byte_cnt_ff == 4'h0) && (rx_byte != `RDQ_READ_TOKEN);
  assign token_taken = byte_done && (byte_cnt_ff == 4'h0) && (rx_byte == `RDQ_READ_TOKEN);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      frame_ff <= rdq_pkg::FR_IDLE;
      bit_cnt_ff <= 3'h0;
      byte_cnt_ff <= 4'h0;
      rx_ff <= 7'h00;
      cmd_ff <= 8'h00;
      arg_ff <= 8'h00;
    end
    else if (sel_s2_ff)
    begin
      frame_ff <= rdq_pkg::FR_IDLE;
      bit_cnt_ff <= 3'h0;
      byte_cnt_ff <= 4'h0;
    end
    else if (sclk_rise)
    begin
      rx_ff <= rx_byte[6:0];
      bit_cnt_ff <= bit_cnt_ff + 3'h1;
      if (bit_cnt_ff == 3'h7)
      begin
        if (byte_cnt_ff != 4'hF)
          byte_cnt_ff <= byte_cnt_ff + 4'h1;
        if (token_taken)
          frame_ff <= rdq_pkg::FR_READ;
        else if (cmd_taken)
        begin
          frame_ff <= rdq_pkg::FR_CMD;
          cmd_ff <= rx_byte;
        end
        else if (byte_cnt_ff == 4'h1)
          arg_ff <= rx_byte;
      end
    end
  end

  // A command frame closes with the select release; only the exact query form executes.
  logic exec_ok, exec_bad;
  assign exec_ok = sel_end && (frame_ff == rdq_pkg::FR_CMD) && (byte_cnt_ff == `RDQ_CMD_BYTES)
                   && (cmd_ff == `RDQ_CMD_STATUS_QUERY);
  assign exec_bad = sel_end && (frame_ff == rdq_pkg::FR_CMD) && !exec_ok;

  // ========================================================================
  // Clear-to-send and error flags
  logic cts_ff, err_ff;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      cts_ff <= 1'b1;
    else if (exec_ok || exec_bad)
      cts_ff <= 1'b1;
    else if (cmd_taken)
      cts_ff <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      err_ff <= 1'b0;
    else if (exec_bad)
      err_ff <= 1'b1;
    else if (exec_ok)
      err_ff <= 1'b0;
  end

  // ========================================================================
  // Receive group queue
  logic [71:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr_ff, rd_ptr_ff;
  logic [7:0] count_ff;
  logic [7:0] thresh_ff;
  logic flush, pop, full, do_push;
  logic [71:0] head;

  assign full = (count_ff == 8'(DEPTH));
  assign flush = (exec_ok && arg_ff[`RDQ_ARG_FLUSH]) || tune_to_frequency_cmd || seek_begin_cmd;
  assign pop = exec_ok && !arg_ff[`RDQ_ARG_FLUSH] && !arg_ff[`RDQ_ARG_PEEK] && (count_ff != 8'h00);
  assign do_push = grp_valid && !flush && (!full || pop);
  assign head = mem[rd_ptr_ff];

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction

  always_ff @(posedge clk)
  begin
    if (do_push)
      mem[wr_ptr_ff] <= {grp_word_a, grp_word_b, grp_word_c, grp_word_d, grp_error_codes};
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= 8'h00;
    end
    else if (flush)
    begin
      rd_ptr_ff <= wr_ptr_ff;
      count_ff <= 8'h00;
    end
    else
    begin
      if (do_push)
        wr_ptr_ff <= ptr_inc(wr_ptr_ff);
      if (pop)
        rd_ptr_ff <= ptr_inc(rd_ptr_ff);
      count_ff <= count_ff + 8'(do_push) - 8'(pop);
    end
  end

  // ========================================================================
  // Decoder state flags, reported and cleared by each executed query; the data-ready flag clears only on an acknowledge
  logic new_a_ff, new_b_ff, sync_acq_ff, sync_drop_ff, overrun_ff, sync_d_ff;
  logic [15:0] last_a_ff, last_b_ff;
  logic [1:0] last_ea_ff, last_eb_ff;
  logic data_ready_irq_flag_ff;
  logic a_ok, b_ok, lost, ready_set;

  assign a_ok = grp_valid && (grp_error_codes[7:6] != `RDQ_ERR_UNCORR);
  assign b_ok = grp_valid && (grp_error_codes[5:4] != `RDQ_ERR_UNCORR);
  assign lost = grp_valid && !flush && full && !pop;
  assign ready_set = do_push && ((count_ff + 8'h01 - 8'(pop)) >= thresh_ff);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      new_a_ff <= 1'b0;
      new_b_ff <= 1'b0;
      sync_acq_ff <= 1'b0;
      sync_drop_ff <= 1'b0;
      overrun_ff <= 1'b0;
      sync_d_ff <= 1'b0;
    end
    else
    begin
      sync_d_ff <= sync_present;
      new_a_ff <= a_ok || (new_a_ff && !exec_ok);
      new_b_ff <= b_ok || (new_b_ff && !exec_ok);
      sync_acq_ff <= (sync_present && !sync_d_ff) || (sync_acq_ff && !exec_ok);
      sync_drop_ff <= (!sync_present && sync_d_ff) || (sync_drop_ff && !exec_ok);
      overrun_ff <= lost || (overrun_ff && !exec_ok);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      last_a_ff <= 16'h0000;
      last_b_ff <= 16'h0000;
      last_ea_ff <= `RDQ_ERR_NONE;
      last_eb_ff <= `RDQ_ERR_NONE;
    end
    else
    begin
      if (a_ok)
      begin
        last_a_ff <= grp_word_a;
        last_ea_ff <= grp_error_codes[7:6];
      end
      if (b_ok)
      begin
        last_b_ff <= grp_word_b;
        last_eb_ff <= grp_error_codes[5:4];
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      data_ready_irq_flag_ff <= 1'b0;
    else if (ready_set)
      data_ready_irq_flag_ff <= 1'b1;
    else if (exec_ok && arg_ff[`RDQ_ARG_ACK])
      data_ready_irq_flag_ff <= 1'b0;
  end

  // ========================================================================
  // Response snapshot taken when the query executes
  logic [7:0] resp_ff [12];
  logic [7:0] status_byte;

  assign status_byte = {cts_ff, err_ff, 2'h0, signal_quality_irq, data_ready_irq_flag_ff,
                        1'b0, seek_tune_done_irq};

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 12; i++)
        resp_ff[i] <= 8'h00;
    end
    else if (exec_ok)
    begin
      resp_ff[0] <= {2'h0, new_b_ff, new_a_ff, 1'b0, sync_acq_ff, sync_drop_ff,
                     count_ff >= thresh_ff};
      resp_ff[1] <= {5'h00, overrun_ff, 1'b0, sync_present};
      resp_ff[2] <= count_ff - 8'(pop);
      if (arg_ff[`RDQ_ARG_PEEK])
      begin
        resp_ff[3] <= last_a_ff[15:8];
        resp_ff[4] <= last_a_ff[7:0];
        resp_ff[5] <= last_b_ff[15:8];
        resp_ff[6] <= last_b_ff[7:0];
        for (int i = 7; i < 11; i++)
          resp_ff[i] <= 8'h00;
        resp_ff[11] <= {last_ea_ff, last_eb_ff, 4'h0};
      end
      else if (pop)
      begin
        for (int i = 0; i < 8; i++)
          resp_ff[3 + i] <= head[71 - 8 * i -: 8];
        resp_ff[11] <= head[7:0];
      end
      else
      begin
        for (int i = 3; i < 12; i++)
          resp_ff[i] <= 8'h00;
      end
    end
  end

  // ========================================================================
  // Response shifter: status byte then twelve reply bytes, MSB first
  logic [7:0] tx_ff;
  logic [3:0] rd_idx_ff;
  logic load_pend_ff;
  logic [7:0] nxt_tx_byte;

  always_comb
  begin
    nxt_tx_byte = 8'h00;
    if (rd_idx_ff == 4'h0)
      nxt_tx_byte = status_byte;
    else if (rd_idx_ff <= `RDQ_RESP_BYTES)
      nxt_tx_byte = resp_ff[rd_idx_ff - 4'h1];
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      tx_ff <= 8'h00;
      rd_idx_ff <= 4'h0;
      load_pend_ff <= 1'b0;
    end
    else if (sel_s2_ff)
    begin
      tx_ff <= 8'h00;
      rd_idx_ff <= 4'h0;
      load_pend_ff <= 1'b0;
    end
    else if (token_taken || (byte_done && frame_ff == rdq_pkg::FR_READ))
      load_pend_ff <= 1'b1;
    else if (sclk_fall)
    begin
      if (load_pend_ff)
      begin
        tx_ff <= nxt_tx_byte;
        if (rd_idx_ff != 4'hF)
          rd_idx_ff <= rd_idx_ff + 4'h1;
        load_pend_ff <= 1'b0;
      end
      else
        tx_ff <= {tx_ff[6:0], 1'b0};
    end
  end

  assign link_sdo = tx_ff[7];
  assign link_sdo_oe = (frame_ff == rdq_pkg::FR_READ);

  // ========================================================================
  // Register port, interrupt status and mask
  logic [3:0] irq_stat_ff, irq_mask_ff, irq_events;
  logic wr_ctrl, wr_stat, wr_mask;

  assign irq_events = {(sync_present != sync_d_ff), lost, ready_set, exec_ok || exec_bad};
  assign wr_ctrl = reg_wr && (reg_addr == `RDQ_REG_CTRL);
  assign wr_stat = reg_wr && (reg_addr == `RDQ_REG_IRQ_STAT);
  assign wr_mask = reg_wr && (reg_addr == `RDQ_REG_IRQ_MASK);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      thresh_ff <= `RDQ_CTRL_RESET;
    else if (wr_ctrl)
      thresh_ff <= reg_wdata[7:0];
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      irq_stat_ff <= 4'h0;
    else
      irq_stat_ff <= irq_events | (irq_stat_ff & ~(wr_stat ? reg_wdata[3:0] : 4'h0));
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      irq_mask_ff <= `RDQ_MASK_RESET;
    else if (wr_mask)
      irq_mask_ff <= reg_wdata[3:0];
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      reg_rdata <= 32'h0000_0000;
    else if (!reg_rd)
      reg_rdata <= 32'h0000_0000;
    else if (reg_addr == `RDQ_REG_CTRL)
      reg_rdata <= {24'h00_0000, thresh_ff};
    else if (reg_addr == `RDQ_REG_IRQ_STAT)
      reg_rdata <= {28'h000_0000, irq_stat_ff};
    else if (reg_addr == `RDQ_REG_IRQ_MASK)
      reg_rdata <= {28'h000_0000, irq_mask_ff};
    else if (reg_addr == `RDQ_REG_STATE)
      reg_rdata <= {21'h00_0000, cts_ff, err_ff, data_ready_irq_flag_ff, count_ff};
    else
      reg_rdata <= 32'h0000_0000;
  end

  assign irq = |(irq_stat_ff & irq_mask_ff);

  // ========================================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_query_run;
    exec_ok ##1 cts_ff;
  endsequence

  a_cts_after_query: assert property (exec_ok |-> s_query_run)
    else $error("CTS not set after query");
  a_cts_busy: assert property (cmd_taken |=> !cts_ff)
    else $error("CTS not dropped when command taken");
  a_ack_clears: assert property (exec_ok && arg_ff[0] && !ready_set |=> !data_ready_irq_flag_ff)
    else $error("Acknowledge did not clear data-ready flag");
  a_noack_keeps: assert property (exec_ok && !arg_ff[0] && data_ready_irq_flag_ff |=> data_ready_irq_flag_ff)
    else $error("Data-ready flag lost without acknowledge");
  a_flush_empties: assert property (flush |=> count_ff == 8'h00)
    else $error("Queue not emptied by flush");
  a_pop_count: assert property (pop && !flush && !grp_valid |=> count_ff == $past(count_ff) - 8'h01)
    else $error("Pop did not remove one group");
  a_peek_keeps: assert property (exec_ok && arg_ff[2] && !flush && !grp_valid
                                 |=> count_ff == $past(count_ff))
    else $error("Peek removed a group");
  a_fill_byte: assert property (exec_ok |=> resp_ff[2] == $past(count_ff) - 8'($past(pop)))
    else $error("Fill count byte wrong");
  a_err_codes: assert property (pop |=> resp_ff[11] == $past(head[7:0]) && resp_ff[3] == $past(head[71:64]))
    else $error("Popped entry not reported");
  a_overrun_flag: assert property (lost |=> overrun_ff && irq_stat_ff[`RDQ_IRQ_OVERRUN])
    else $error("Overrun not flagged");
  a_sync_now: assert property (exec_ok |=> resp_ff[1][0] == $past(sync_present))
    else $error("Sync present bit wrong");

endmodule

/* File: verif/rdq_host_model.sv */
// Host controller model that sends query frames and read frames on the serial link.
// Assumes the device samples select, clock and data on its own clock.
`timescale 1ns/1ps
`include "rdq_regs.svh"
module rdq_host_model (
  output logic link_sel_n,
  output logic link_sclk,
  output logic link_sdi,
  input wire logic link_sdo
);
  // ==========================================================================
  // Frame engine
  initial
  begin
    link_sel_n = 1'b1;
    link_sclk = 1'b0;
    link_sdi = 1'b0;
  end

  // The clock only runs inside a frame, and data flips once select is released.
  task automatic xfer(input int nbits, input logic [111:0] tx, output logic [111:0] rx);
    rx = '0;
    link_sel_n = 1'b0;
    #80;
    for (int i = 0; i < nbits; i++)
    begin
      link_sdi = tx[111 - i];
      #80;
      rx = {rx[110:0], link_sdo};
      link_sclk = 1'b1;
      #80;
      link_sclk = 1'b0;
    end
    #80;
    link_sel_n = 1'b1;
    link_sdi = ~link_sdi;
    #320;
  endtask

  // ==========================================================================
  // Command and reply frames
  task automatic send_query(input logic [7:0] code, input logic [7:0] arg);
    logic [111:0] rx;
    xfer(16, {code, 5'h00, arg[2:0], 96'h0}, rx);
  endtask

  task automatic read_reply(output logic [103:0] resp);
    logic [111:0] rx;
    xfer(112, {`RDQ_READ_TOKEN, 104'h0}, rx);
    resp = rx[103:0];
  endtask
endmodule

/* File: verif/tb_radio_data_status_fifo_read.sv */
// Self-checking bench of the status query block with a host model on the link.
// Assumes the design files and the constants header are compiled first.
`timescale 1ns/1ps
`include "rdq_regs.svh"
module tb_radio_data_status_fifo_read;
  localparam int DEPTH = 4;
  typedef struct {logic [7:0] arg; logic [103:0] exp;} rdq_row_t;
  logic clk, rst_n, sel_n, sclk, sdi, sdo, sdo_oe, gv, sync, tune, seek, sq, stc, wr, rd, irq;
  logic [15:0] wa, wb, wc, wd;
  logic [7:0] ge, addr;
  logic [31:0] wdata, rdata, d;
  logic [103:0] r;
  rdq_row_t rows[4];
  int miscompares, checks_done;

  rdq_status_query #(.DEPTH(DEPTH)) rdq_status_query_i (.clk(clk), .rst_n(rst_n), .link_sel_n(sel_n),
    .link_sclk(sclk), .link_sdi(sdi), .link_sdo(sdo), .link_sdo_oe(sdo_oe), .grp_valid(gv),
    .grp_word_a(wa), .grp_word_b(wb), .grp_word_c(wc), .grp_word_d(wd), .grp_error_codes(ge),
    .sync_present(sync), .tune_to_frequency_cmd(tune), .seek_begin_cmd(seek), .signal_quality_irq(sq),
    .seek_tune_done_irq(stc), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
    .reg_rdata(rdata), .irq(irq));
  rdq_host_model rdq_host_model_i (.link_sel_n(sel_n), .link_sclk(sclk), .link_sdi(sdi), .link_sdo(sdo));

  // ==========================================================================
  // Clock, watchdog and helpers
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial
  begin
    #600_000;
    miscompares++;
    close_out();
  end

  function automatic logic [15:0] gw(input int k, input int w);
    return {4'hA + w[3:0], k[3:0], 8'hC3};
  endfunction

  function automatic logic [103:0] mk(input logic [7:0] st, r1, r2, cnt, input int k, input logic [7:0] e);
    logic [63:0] w;
    w = (k >= 0) ? {gw(k, 0), gw(k, 1), gw(k, 2), gw(k, 3)} : {gw(2, 0), gw(2, 1), 32'h0};
    return {st, r1, r2, cnt, w, e};
  endfunction

  task automatic chk(input logic [103:0] e, input logic [103:0] g);
    checks_done++;
    if (g !== e)
    begin
      miscompares++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic push(input int k);
    @(posedge clk);
    gv <= 1'b1;
    {wa, wb, wc, wd} <= {gw(k, 0), gw(k, 1), gw(k, 2), gw(k, 3)};
    ge <= 8'h1B;
    @(posedge clk);
    gv <= 1'b0;
  endtask

  task automatic rw(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rr(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic q(input logic [7:0] arg, output logic [103:0] resp);
    rdq_host_model_i.send_query(`RDQ_CMD_STATUS_QUERY, arg);
    rdq_host_model_i.read_reply(resp);
  endtask

  task automatic close_out;
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial
  begin
    {rst_n, gv, sync, tune, seek, wr, rd, stc} = '0;
    {wa, wb, wc, wd, ge, addr, wdata} = '0;
    sq = 1'b1;
    rows[0] = '{8'h00, mk(8'h8C, 8'h35, 8'h01, 8'h02, 0, 8'h1B)};
    rows[1] = '{8'h04, mk(8'h8C, 8'h01, 8'h01, 8'h02, -1, 8'h10)};
    rows[2] = '{8'h01, mk(8'h88, 8'h01, 8'h01, 8'h01, 1, 8'h1B)};
    rows[3] = '{8'h00, mk(8'h88, 8'h01, 8'h01, 8'h00, 2, 8'h1B)};
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    // Queries start only once the device is out of reset.
    chk({irq, sdo_oe}, 2'b00);
    rr(`RDQ_REG_CTRL, d);
    chk(`RDQ_CTRL_RESET, d[7:0]);
    rr(`RDQ_REG_IRQ_MASK, d);
    chk(`RDQ_MASK_RESET, d[3:0]);
    rr(8'h10, d);
    chk(32'h0, d);
    sync <= 1'b1;
    for (int k = 0; k < 3; k++)
      push(k);
    for (int i = 0; i < 4; i++)
    begin
      q(rows[i].arg, r);
      chk(rows[i].exp, r);
    end
    // Tune, seek and the flush argument each leave the queue empty.
    for (int s = 0; s < 3; s++)
    begin
      push(0);
      push(1);
      @(posedge clk);
      {tune, seek} <= (s == 0) ? 2'b10 : (s == 1) ? 2'b01 : 2'b00;
      @(posedge clk);
      {tune, seek} <= 2'b00;
      if (s == 2)
        q(8'h02, r);
      rr(`RDQ_REG_STATE, d);
      chk(8'h00, d[7:0]);
    end
    // Overrun at the threshold boundary, with the interrupt masked in and cleared.
    rw(`RDQ_REG_CTRL, 32'h4);
    rw(`RDQ_REG_IRQ_STAT, 32'hF);
    rw(`RDQ_REG_IRQ_MASK, 32'h4);
    for (int k = 0; k < DEPTH + 1; k++)
      push(k);
    rr(`RDQ_REG_STATE, d);
    chk({irq, d[7:0]}, {1'b1, 8'h04});
    q(8'h00, r);
    chk(mk(8'h8C, 8'h31, 8'h05, 8'h03, 0, 8'h1B), r);
    rw(`RDQ_REG_IRQ_STAT, 32'h4);
    @(posedge clk);
    chk(1'b0, irq);
    q(8'h01, r);
    chk(24'h000102, r[95:72]);
    @(posedge clk);
    sync <= 1'b0;
    {sq, stc} <= 2'b01;
    q(8'h00, r);
    chk(24'h020001, r[95:72]);
    // Uncorrectable A and B words leave the last valid pair in place for a peek.
    @(posedge clk);
    gv <= 1'b1;
    ge <= 8'hF0;
    @(posedge clk);
    gv <= 1'b0;
    ge <= 8'h1B;
    q(8'h04, r);
    chk({r[95:88], r[71:0]}, {8'h00, gw(4, 0), gw(4, 1), 32'h0, 8'h10});
    // A wrong command code is refused but the link stays ready.
    rdq_host_model_i.send_query(8'h25, 8'h00);
    rdq_host_model_i.read_reply(r);
    chk(8'hC1, r[103:96]);
    rr(`RDQ_REG_STATE, d);
    chk(32'h0000_0602, d);
    // A reset in mid-run empties the queue and clears the error flag.
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rr(`RDQ_REG_STATE, d);
    chk({irq, d}, {1'b0, 32'h0000_0400});
    close_out();
  end
endmodule
